//--- include/sarcs_pkg.sv
// sarcs_pkg: constants and carrier types of the conversion sequencer
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package sarcs_pkg;
	// ------------------------------------------------------------
	// widths and codes
	// ------------------------------------------------------------
	localparam int unsigned RES_BITS = 18;
	localparam logic [17:0] CODE_MID = 18'h00000;
	localparam logic [17:0] CODE_POS_FS = 18'h1FFFF;
	localparam logic [17:0] CODE_NEG_FS = 18'h20000;
	localparam logic [17:0] CODE_RESET = 18'h00000;
	localparam logic [4:0] MSB_INDEX = 5'h11;
	localparam logic [4:0] BIT_FIELD_POS = 5'h00;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 125;
	// shortest conversion period at 1 msps, in ns
	localparam int unsigned CONV_PERIOD_NS = 1000;
	localparam int unsigned CONV_PERIOD_CYC = (CONV_PERIOD_NS * CLK_MHZ) / 1000;
	// internal oscillator: one bit trial every TRIAL_CYC system cycles
	localparam int unsigned TRIAL_CYC = 4;
	localparam logic [2:0] TRIAL_LAST = 3'(TRIAL_CYC - 1);
	// settle cycles after opening the sampling switches
	localparam logic [2:0] SETTLE_LAST = 3'h1;
	localparam int unsigned SHIFT_BITS = 18;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		SARCS_ACQ = 5'h01,
		SARCS_OPEN = 5'h02,
		SARCS_HOLD = 5'h04,
		SARCS_TRIAL = 5'h08,
		SARCS_DONE = 5'h10
	} sarcs_state_t;
	typedef struct packed {
		logic over_range;
		logic under_range;
		logic [17:0] code;
	} sarcs_result_t;
endpackage
`default_nettype wire

//--- rtl/sarcs_sequencer.sv
// sarcs_sequencer: control logic of an 18-bit charge-redistribution
// converter, from convert edge to serial result
// assumes comparator, range flags and serial inputs synchronous to sys_clk_i
`default_nettype none
`timescale 1ns/100ps
module sarcs_sequencer (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic convert_strobe_i,
	input wire logic comparator_i,
	input wire logic over_range_i,
	input wire logic under_range_i,
	input wire logic shift_clk_i,
	input wire logic read_enable_n_i,
	output logic sample_switch_pos_o,
	output logic sample_switch_neg_o,
	output logic array_to_ground_o,
	output logic [17:0] dac_ref_o,
	output logic convert_power_o,
	output logic busy_o,
	output logic result_valid_o,
	output logic [17:0] result_o,
	output logic serial_data_out_o,
	output logic serial_data_oe_n_o
);
	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [17:0] bit_mask(input logic [4:0] idx);
		bit_mask = 18'h00001 << idx;
	endfunction

	// ------------------------------------------------------------
	// edge detection and state
	// ------------------------------------------------------------
	sarcs_pkg::sarcs_state_t state_q, state_d;
	logic cnv_prev_q;
	logic shift_prev_q;
	logic [2:0] tick_q, tick_d;
	logic [4:0] bit_q, bit_d;
	logic [17:0] trial_q, trial_d;
	logic over_q, over_d;
	logic under_q, under_d;
	logic busy_q, busy_d;

	wire cnv_rise = convert_strobe_i & ~cnv_prev_q;
	wire shift_rise = shift_clk_i & ~shift_prev_q;
	wire in_acq = (state_q == sarcs_pkg::SARCS_ACQ);
	// edges outside acquisition are simply dropped
	wire start = cnv_rise & in_acq;
	wire tick_end = (tick_q == sarcs_pkg::TRIAL_LAST);
	wire last_bit = (bit_q == sarcs_pkg::BIT_FIELD_POS);
	wire settle_end = (tick_q == sarcs_pkg::SETTLE_LAST);
	wire in_hold = (state_q == sarcs_pkg::SARCS_HOLD);
	wire in_trial = (state_q == sarcs_pkg::SARCS_TRIAL);
	wire in_done = (state_q == sarcs_pkg::SARCS_DONE);
	wire [4:0] next_bit = bit_q - 5'h01;

	// ------------------------------------------------------------
	// result formatting
	// ------------------------------------------------------------
	// the array works on offset binary; flipping the msb gives two's
	// complement with midscale at zero
	wire [17:0] final_bits = comparator_i ? trial_q : (trial_q & ~bit_mask(bit_q));
	// in the done state the trial word already holds the finished code, so
	// the pushed word does not depend on a comparator that is idle by then
	wire [17:0] twos_code = {~trial_q[17], trial_q[16:0]};
	wire [17:0] sat_code = over_q ? sarcs_pkg::CODE_POS_FS :
		(under_q ? sarcs_pkg::CODE_NEG_FS : twos_code);
	sarcs_pkg::sarcs_result_t done_word;
	assign done_word = {over_q, under_q, sat_code};

	// ------------------------------------------------------------
	// sequencer next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		tick_d = tick_q;
		bit_d = bit_q;
		trial_d = trial_q;
		over_d = over_q;
		under_d = under_q;
		busy_d = busy_q;
		case (state_q)
			sarcs_pkg::SARCS_ACQ: begin
				if (start) begin
					state_d = sarcs_pkg::SARCS_OPEN;
					tick_d = 3'h0;
					busy_d = 1'b1;
					// msb trial word is ready before the arrays are grounded,
					// so no stale code from the last conversion reaches them
					bit_d = sarcs_pkg::MSB_INDEX;
					trial_d = bit_mask(sarcs_pkg::MSB_INDEX);
				end
			end
			sarcs_pkg::SARCS_OPEN: begin
				// switches open before the arrays leave the inputs
				tick_d = tick_q + 3'h1;
				if (settle_end) begin
					state_d = sarcs_pkg::SARCS_HOLD;
					tick_d = 3'h0;
				end
			end
			sarcs_pkg::SARCS_HOLD: begin
				// range flags caught with this sample only
				over_d = over_range_i;
				under_d = under_range_i;
				state_d = sarcs_pkg::SARCS_TRIAL;
			end
			sarcs_pkg::SARCS_TRIAL: begin
				tick_d = tick_q + 3'h1;
				if (tick_end) begin
					tick_d = 3'h0;
					if (last_bit) begin
						trial_d = final_bits;
						state_d = sarcs_pkg::SARCS_DONE;
					end else begin
						// keep or drop this bit, then try the next lower one
						trial_d = final_bits | bit_mask(next_bit);
						bit_d = next_bit;
					end
				end
			end
			sarcs_pkg::SARCS_DONE: begin
				state_d = sarcs_pkg::SARCS_ACQ;
				busy_d = 1'b0;
			end
			default: begin
				state_d = sarcs_pkg::SARCS_ACQ;
				busy_d = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	// one short process per group keeps each reset value next to its use
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cnv_prev_q <= 1'b0;
			shift_prev_q <= 1'b0;
		end else begin
			cnv_prev_q <= convert_strobe_i;
			shift_prev_q <= shift_clk_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_q <= sarcs_pkg::SARCS_ACQ;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			tick_q <= 3'h0;
		end else begin
			tick_q <= tick_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bit_q <= 5'h00;
			trial_q <= sarcs_pkg::CODE_RESET;
		end else begin
			bit_q <= bit_d;
			trial_q <= trial_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			over_q <= 1'b0;
			under_q <= 1'b0;
		end else begin
			over_q <= over_d;
			under_q <= under_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	// ------------------------------------------------------------
	// analog switch drive
	// ------------------------------------------------------------
	assign sample_switch_pos_o = in_acq;
	assign sample_switch_neg_o = in_acq;
	wire arrays_grounded = in_hold | in_trial;
	assign array_to_ground_o = arrays_grounded;
	assign dac_ref_o = arrays_grounded ? trial_q : 18'h00000;
	// comparator and dac bias only while converting
	assign convert_power_o = ~in_acq;
	assign busy_o = busy_q;

	// ------------------------------------------------------------
	// two-entry result buffer
	// ------------------------------------------------------------
	// a fresh result while both entries wait is dropped; at 1 msps the
	// reader has one period per word, so that only hits a stalled reader
	sarcs_pkg::sarcs_result_t buf_q [0:1];
	logic wr_ptr_q, rd_ptr_q;
	logic [1:0] count_q;
	wire push_valid = in_done;
	wire push_ready = (count_q != 2'h2);
	wire pop_valid = (count_q != 2'h0);
	logic pop_ready;
	wire push = push_valid & push_ready;
	wire pop = pop_valid & pop_ready;

	wire [1:0] count_d = count_q + {1'b0, push} - {1'b0, pop};
	sarcs_pkg::sarcs_result_t head_word;
	assign head_word = buf_q[rd_ptr_q];

	// storage needs no reset: an entry is only read after it was pushed
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			buf_q[wr_ptr_q] <= done_word;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			count_q <= count_d;
		end
	end

	// ------------------------------------------------------------
	// serial shifter
	// ------------------------------------------------------------
	logic [17:0] shift_q;
	logic [4:0] left_q;
	logic sdo_q;
	logic res_valid_q;
	logic [17:0] result_q;
	wire shifter_idle = (left_q == 5'h00);
	assign pop_ready = shifter_idle & ~read_enable_n_i;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			res_valid_q <= 1'b0;
			result_q <= sarcs_pkg::CODE_RESET;
		end else begin
			res_valid_q <= pop;
			if (pop) begin
				result_q <= head_word.code;
			end
		end
	end

	// ------------------------------------------------------------
	// shift register
	// ------------------------------------------------------------
	// a shift edge while the select is high is lost, not deferred
	wire shift_step = shift_rise & ~shifter_idle & ~read_enable_n_i;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			shift_q <= 18'h00000;
			left_q <= 5'h00;
			sdo_q <= 1'b0;
		end else if (pop) begin
			// msb goes out at once, the rest on shift clock edges
			shift_q <= {head_word.code[16:0], 1'b0};
			sdo_q <= head_word.code[17];
			left_q <= 5'(sarcs_pkg::SHIFT_BITS);
		end else if (shift_step) begin
			sdo_q <= shift_q[17];
			shift_q <= {shift_q[16:0], 1'b0};
			left_q <= left_q - 5'h01;
		end
	end

	assign serial_data_out_o = sdo_q;
	assign serial_data_oe_n_o = read_enable_n_i;
	assign result_valid_o = res_valid_q;
	assign result_o = result_q;
endmodule // sarcs_sequencer
`default_nettype wire

//--- verification/sarcs_far_model.sv
// sarcs_far_model: track-and-hold and comparator of the analog side
// assumes dac_ref offset binary, switches high while tracking
`timescale 1ns/100ps
`default_nettype none
module sarcs_far_model (
	input wire logic sys_clk_i,
	input wire logic switch_i,
	input wire logic [17:0] dac_ref_i,
	input wire logic [17:0] level_i,
	input wire logic [1:0] range_i,
	output logic comparator_o,
	output logic [1:0] range_o
);
	logic [17:0] held_q;
	// input only tracked while the switches are closed
	always_ff @(posedge sys_clk_i) begin
		if (switch_i) begin
			held_q <= level_i;
			range_o <= range_i;
		end
	end
	assign comparator_o = dac_ref_i <= held_q;
endmodule // sarcs_far_model
`default_nettype wire

//--- verification/sarcs_monitor.sv
// sarcs_monitor: port checks of the conversion sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sarcs_monitor (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic convert_strobe_i,
	input wire logic read_enable_n_i,
	input wire logic sample_switch_pos_o,
	input wire logic sample_switch_neg_o,
	input wire logic array_to_ground_o,
	input wire logic [17:0] dac_ref_o,
	input wire logic convert_power_o,
	input wire logic busy_o,
	input wire logic result_valid_o,
	input wire logic [17:0] result_o,
	input wire logic serial_data_out_o,
	input wire logic serial_data_oe_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	edge_taken_a: assert property ($rose(convert_strobe_i) &&
		!convert_power_o |=> busy_o) else $error("edge not taken");
	switch_first_a: assert property ($rose(array_to_ground_o) |->
		!$past(sample_switch_pos_o, 2)) else $error("ground before open");
	busy_open_a: assert property (busy_o |-> !sample_switch_pos_o)
		else $error("switch closed while busy");
	msb_trial_a: assert property ($rose(array_to_ground_o) |->
		dac_ref_o == 18'h20000) else $error("first trial not msb");
	conv_len_a: assert property ($rose(busy_o) |->
		##75 busy_o ##1 !busy_o) else $error("conversion length");
	power_gate_a: assert property (convert_power_o == busy_o)
		else $error("power outside conversion");
	valid_pulse_a: assert property (result_valid_o |=>
		!result_valid_o) else $error("valid too long");
	msb_out_a: assert property (result_valid_o |->
		serial_data_out_o == result_o[17]) else $error("serial msb");
	switch_pair_a: assert property (sample_switch_neg_o ==
		sample_switch_pos_o) else $error("switch halves differ");
	drive_select_a: assert property (serial_data_oe_n_o ==
		read_enable_n_i) else $error("output enable not select");
	cover property ($rose(busy_o));
	cover property ($rose(convert_strobe_i) && busy_o);
	cover property (result_valid_o && result_o == sarcs_pkg::CODE_POS_FS);
	cover property (result_valid_o && result_o == sarcs_pkg::CODE_NEG_FS);
endmodule // sarcs_monitor
bind sarcs_sequencer sarcs_monitor u_mon (.*);
`default_nettype wire

//--- verification/test_sarcs_sequencer.sv
// test_sarcs_sequencer: directed scenarios for the sequencer
// assumes the far model for comparator and range flags
`timescale 1ns/100ps
`default_nettype none
module test_sarcs_sequencer;
	logic clk = 1'b0, rst = 1'b1, convert_strobe = 1'b0, sck = 1'b0, rd_n = 1'b1;
	logic cmp, sw_p, busy, vld, serial_data_out;
	logic [1:0] rg = 2'h0, rg_r;
	logic [17:0] lvl = 18'h00000, dac, res;
	int miscompares = 0, cmp_count = 0;
	always #4 clk = ~clk;
	sarcs_sequencer u_dut (.sys_clk_i(clk), .reset_i(rst),
		.convert_strobe_i(convert_strobe), .comparator_i(cmp), .over_range_i(rg_r[1]),
		.under_range_i(rg_r[0]), .shift_clk_i(sck), .read_enable_n_i(rd_n),
		.sample_switch_pos_o(sw_p), .sample_switch_neg_o(),
		.array_to_ground_o(), .dac_ref_o(dac), .convert_power_o(),
		.busy_o(busy), .result_valid_o(vld), .result_o(res),
		.serial_data_out_o(serial_data_out), .serial_data_oe_n_o());
	sarcs_far_model u_far (.sys_clk_i(clk), .switch_i(sw_p),
		.dac_ref_i(dac), .level_i(lvl), .range_i(rg),
		.comparator_o(cmp), .range_o(rg_r));
	task automatic check(logic [17:0] seen, logic [17:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic await(logic on_valid);
		int n = 0;
		while (n < 300 && (on_valid ? vld !== 1'b1 : busy !== 1'b0)) begin
			@(posedge clk);
			n++;
		end
		if (n == 300) begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic read_word(logic [17:0] exp);
		logic [17:0] got;
		rd_n <= 1'b0;
		await(1'b1);
		check(res, exp);
		got[17] = serial_data_out;
		for (int i = 17; i >= 0; i--) begin
			sck <= 1'b1;
			@(posedge clk);
			// drop the select as the last shift lands, before the idle
			// shifter would pull the next buffered word
			if (i == 0) rd_n <= 1'b1;
			repeat (2) @(posedge clk);
			sck <= 1'b0;
			if (i > 0) got[i - 1] = serial_data_out;
			repeat (3) @(posedge clk);
		end
		check(got, exp);
		@(posedge clk);
	endtask
	task automatic t_codes;
		logic [17:0] lv [6] = '{18'h20000, 18'h20001, 18'h1FFFF,
			18'h3FFFF, 18'h00005, 18'h3FFF0};
		logic [17:0] ex [6] = '{18'h00000, 18'h00001, 18'h3FFFF,
			18'h1FFFF, 18'h1FFFF, 18'h20000};
		logic [1:0] fl [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
		for (int i = 0; i < 6; i++) begin
			rg <= fl[i];
			lvl <= lv[i];
			convert_strobe <= 1'b1;
			@(posedge clk);
			convert_strobe <= 1'b0;
			// moving input after the edge must not reach the result
			lvl <= ~lv[i];
			repeat (2) @(posedge clk);
			await(1'b0);
			read_word(ex[i]);
		end
		$display("codes test done");
	endtask
	task automatic t_burst;
		int hits = 0;
		rg <= 2'h0;
		for (int i = 0; i < 3; i++) begin
			lvl <= 18'h20010 + 18'(i);
			convert_strobe <= 1'b1;
			@(posedge clk);
			convert_strobe <= 1'b0;
			repeat (40) @(posedge clk);
			convert_strobe <= 1'b1;
			@(posedge clk);
			convert_strobe <= 1'b0;
			// 125 cycles from start to start: the top conversion rate
			repeat (83) @(posedge clk);
		end
		read_word(18'h00010);
		read_word(18'h00011);
		rd_n <= 1'b0;
		repeat (100) begin
			@(posedge clk);
			hits += vld;
		end
		rd_n <= 1'b1;
		check(18'(hits), 18'h00000);
		$display("burst test done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_codes();
		t_burst();
		summarize();
	end
endmodule // test_sarcs_sequencer
`default_nettype wire
